// ==== bench/dsfb_drive_model.sv ====
// drive mechanism: head position and status pins
`timescale 1ns/1ps
module dsfb_drive_model (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // step command
    input wire logic stepGo,
    input wire logic [9:0] stepTo,
    // status levels
    output logic [3:0] drivePins
);
    logic [9:0] cylReg;
    logic seekReg;
    // heads move on each step, seek flag stays up after
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cylReg <= '0;
            seekReg <= 1'h0;
        end else if (stepGo) begin
            cylReg <= stepTo;
            seekReg <= 1'h1;
        end
    end
    assign drivePins = {cylReg == 10'h0, 1'h0, seekReg, 1'h0};
endmodule : dsfb_drive_model

// ==== bench/dsfb_top_assertions.sv ====
// port checks for the sense and format block
`timescale 1ns/1ps
`include "dsfb_cfg.svh"
module dsfb_top_assertions #(
    parameter logic [9:0] LAST_CYL = 10'h3FF
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [7:0] wb_dat_i,
    input wire logic wb_ack_o,
    // controls
    input wire logic eccEnable,
    input wire logic [3:0] retryLimit,
    input wire logic halted,
    input wire logic stepReq,
    input wire logic [9:0] stepTarget,
    input wire logic stepGo,
    input wire logic [9:0] stepTo,
    input wire dsfb_pkg::dsfb_entry_t fmtEntry,
    input wire logic fmtBadTrack
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // bus answers one cycle after a taken request
    ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack unasked");
    // recovery setup defaults and writes
    setup_default_a: assert property ($rose(rst_n) |-> eccEnable && retryLimit == 4'hF) else $error("bad setup default");
    setup_write_a: assert property (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == `DSFB_ADDR_SETUP
        |-> ##2 eccEnable == $past(wb_dat_i[7], 2) && retryLimit == $past(wb_dat_i[3:0], 2)) else $error("setup lost");
    halt_sticky_a: assert property (halted |=> halted) else $error("halt dropped");
    // stepping limits
    no_overstep_a: assert property (stepReq && stepTarget > LAST_CYL |-> !stepGo) else $error("stepped past limit");
    step_clamp_a: assert property (stepGo |-> stepReq && stepTo <= LAST_CYL) else $error("bad step");
    bad_track_a: assert property (fmtBadTrack |-> &fmtEntry) else $error("false bad track");
endmodule : dsfb_top_assertions

// ==== bench/dsfb_top_test.sv ====
// self-checking bench for the sense and format block
`timescale 1ns/1ps
`include "dsfb_cfg.svh"
module dsfb_top_test;
    localparam logic [9:0] LC = 10'h1F0;
    localparam logic [7:0] DT = 8'h3C; // arbitrary type code
    logic clock = 1'h0, rst_n = 1'h0, wbCyc = 1'h0, wbStb = 1'h0, wbWe = 1'h0;
    logic [3:0] wbAdr = '0, stageFlags = '0, stepHead = '0, retryLimit, pins;
    logic [7:0] wbDatI = '0, wbDatO, rd;
    logic wbAck, eccEnable, halted, stepGo, fmtBadTrack;
    logic [9:0] stepTo, stepTarget = '0, cyl;
    logic [12:0] ev = '0;
    logic [15:0] seed = 16'hD8AF;
    logic [7:0] lay [10];
    logic [13:0][7:0] want;
    dsfb_pkg::dsfb_drive_t flags = '0, f;
    dsfb_pkg::dsfb_entry_t idField = '0, fmtEntry, i;
    int badCount = 0, comparisons = 0;
    dsfb_top #(.DRIVE_TYPE(DT), .LAST_CYL(LC)) dsfb_top_inst (.clock(clock),
        .rst_n(rst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
        .wb_adr_i(wbAdr), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
        .wb_ack_o(wbAck), .drivePins(pins), .driveFlags(flags),
        .cmdDone(ev[0]), .cmdError(ev[1]), .stageStart(ev[2]),
        .stageXfer(ev[3]), .stageValid(ev[4]), .stageTrack(ev[5]),
        .stageFlags(stageFlags), .xferDone(ev[6]), .idSeen(ev[7]),
        .idField(idField), .eccFixed(ev[8]), .retryPulse(ev[9]),
        .opStart(ev[10]), .stepReq(ev[11]), .stepPark(1'h0),
        .stepTarget(stepTarget), .stepHead(stepHead), .eccEnable(eccEnable),
        .retryLimit(retryLimit), .halted(halted), .stepTo(stepTo),
        .stepGo(stepGo), .fmtNext(ev[12]), .fmtWholeDisk(1'h0),
        .fmtEntry(fmtEntry), .fmtBadTrack(fmtBadTrack), .fmtPos());
    dsfb_drive_model dsfb_drive_model_inst (.clock(clock), .rst_n(rst_n),
        .stepGo(stepGo), .stepTo(stepTo), .drivePins(pins));
    // free-running clock and hang guard
    initial forever #2.5 clock = ~clock;
    initial begin
        #20000;
        badCount++;
        completeRun();
    end
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr
    // expected status bytes, overstep and seek always set here
    function automatic logic [13:0][7:0] expStat(input dsfb_pkg::dsfb_drive_t g,
        input dsfb_pkg::dsfb_entry_t d, input logic [9:0] c, input logic [3:0] h);
        return {8'h00, DT, 8'hA4, 8'h02, 8'h03, c[7:0], {h, 2'h0, c[9:8]},
            d.sizeCode, d.sector, {d.defective, d.cylHigh, 1'h0, d.head},
            d.cylLow, {1'h0, g.resetNeeded, g.retryCorrected, d.defective,
            g.headSelect}, {g.errorFieldIsId, g.checkError,
            g.addressMarkMissing, g.allOnesId, g.cylinderMismatch, 2'h0,
            g.idNotFound}, {g.notReady, 1'h1, 1'h0, g.writeFault, 1'h1, 2'h0,
            g.trackZero}};
    endfunction : expStat
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            badCount++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // one classic cycle, request held until ack is sampled
    task automatic wb(input logic we, input logic [3:0] a, input logic [7:0] d);
        int n = 0;
        wbCyc <= 1'h1;
        wbStb <= 1'h1;
        wbWe <= we;
        wbAdr <= a;
        wbDatI <= d;
        do begin
            @(posedge clock);
            n++;
        end while (wbAck !== 1'h1 && n < 40);
        rd = wbDatO;
        if (n >= 40) badCount++;
        wbCyc <= 1'h0;
        wbStb <= 1'h0;
        @(posedge clock);
    endtask : wb
    task automatic pulse(input int k);
        ev[k] <= 1'h1;
        @(posedge clock);
        ev[k] <= 1'h0;
        @(posedge clock);
    endtask : pulse
    task automatic completeRun();
        $display("comparisons %0d mismatches %0d", comparisons, badCount);
        if (badCount == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : completeRun
    initial begin
        repeat (3) @(posedge clock);
        rst_n <= 1'h1;
        @(posedge clock);
        check(eccEnable, 1'h1);
        check(retryLimit, 4'hF);
        repeat (4) begin
            seed = lfsr(seed);
            wb(1'h1, `DSFB_ADDR_SETUP, seed[7:0] & 8'h8F);
            check(eccEnable, seed[7]);
            check(retryLimit, seed[3:0]);
        end
        // one operation's worth of events, then fetch the status block
        pulse(10);
        seed = lfsr(seed);
        f = seed;
        i = {seed[11:5], seed, 8'h02, seed[7:0]};
        cyl = {2'h0, seed[7:0]} | 10'h001;
        flags <= f;
        idField <= i;
        stepTarget <= cyl;
        stepHead <= seed[3:0];
        want = expStat(f, i, cyl, seed[3:0]);
        pulse(11);
        stepTarget <= 10'h3F0;
        pulse(11);
        pulse(7);
        repeat (3) pulse(8);
        repeat (2) pulse(9);
        for (int k = 2; k < 6; k++) pulse(k);
        stageFlags <= 4'hA;
        @(posedge clock);
        stageFlags <= 4'h0;
        pulse(6);
        pulse(1);
        pulse(0);
        repeat (4) @(posedge clock);
        wb(1'h1, `DSFB_ADDR_CTRL, 8'h20);
        for (int k = 0; k < 14; k++) begin
            wb(1'h0, `DSFB_ADDR_STAT, 8'h00);
            check(rd[4], 1'h1);
            wb(1'h0, `DSFB_ADDR_DATA, 8'h00);
            check(rd, want[k]);
        end
        wb(1'h0, `DSFB_ADDR_STAT, 8'h00);
        check(rd[4], 1'h0);
        repeat (252) pulse(9);
        check(halted, 1'h0);
        pulse(9);
        check(halted, 1'h1);
        // layout list kept and replayed in order
        wb(1'h1, `DSFB_ADDR_CTRL, 8'h40);
        for (int k = 0; k < 10; k++) begin
            seed = lfsr(seed);
            lay[k] = seed[7:0];
            wb(1'h1, `DSFB_ADDR_LAYOUT, lay[k]);
        end
        wb(1'h0, `DSFB_ADDR_FMT, 8'h00);
        check(rd, 8'h02);
        for (int k = 0; k < 10; k += 5) begin
            check(fmtEntry, {lay[k][7:4], lay[k][2:0], lay[k+1], lay[k+2],
                lay[k+3], lay[k+4]});
            pulse(12);
        end
        wb(1'h1, `DSFB_ADDR_CTRL, 8'h40);
        for (int k = 0; k < 6; k++) wb(1'h1, `DSFB_ADDR_LAYOUT, k < 5 ? 8'hFF : 8'h00);
        check(fmtBadTrack, 1'h1);
        wb(1'h0, 4'h9, 8'h00);
        check(rd, 8'h00);
        completeRun();
    end
endmodule : dsfb_top_test
bind dsfb_top dsfb_top_assertions #(.LAST_CYL(LAST_CYL)) chk (.clock(clock),
    .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
    .eccEnable(eccEnable), .retryLimit(retryLimit), .halted(halted),
    .stepReq(stepReq), .stepTarget(stepTarget), .stepGo(stepGo),
    .stepTo(stepTo), .fmtEntry(fmtEntry), .fmtBadTrack(fmtBadTrack));

// ==== hw/dsfb_cfg.svh ====
// register offsets, field positions and reset values for the sense block
`ifndef DSFB_CFG_SVH
`define DSFB_CFG_SVH
`define DSFB_ADDR_CTRL 4'h0
`define DSFB_ADDR_SETUP 4'h1
`define DSFB_ADDR_DATA 4'h2
`define DSFB_ADDR_STAT 4'h3
`define DSFB_ADDR_LAYOUT 4'h4
`define DSFB_ADDR_FMT 4'h5
`define DSFB_ECC_BIT 7
`define DSFB_SETUP_RST 8'h8F
`define DSFB_STATUS_LEN 5'h0E
`define DSFB_ENTRY_LEN 3'h5
`define DSFB_SIZE_CODE 8'h02
`define DSFB_RETRY_MAX 8'hFF
`define DSFB_SYN_START 8'h00
`define DSFB_SYN_XFER 8'h01
`define DSFB_SYN_VALID 8'h02
`define DSFB_SYN_TRACK 8'h03
`define DSFB_SYN_DONE 4'h4
`endif

// ==== hw/dsfb_pkg.sv ====
// types shared by the sense and format block logic
package dsfb_pkg;
    typedef struct packed {
        logic [1:0] cylHigh;
        logic [7:0] cylLow;
        logic [3:0] head;
    } dsfb_pos_t;
    typedef struct packed {
        logic [3:0] head;
        logic defective;
        logic [1:0] cylHigh;
        logic [7:0] cylLow;
        logic [7:0] sector;
        logic [7:0] sizeCode;
        logic [7:0] fill;
    } dsfb_entry_t;
    typedef struct packed {
        logic notReady;
        logic seekDone;
        logic writeFault;
        logic trackZero;
        logic checkError;
        logic errorFieldIsId;
        logic addressMarkMissing;
        logic allOnesId;
        logic cylinderMismatch;
        logic idNotFound;
        logic resetNeeded;
        logic retryCorrected;
        logic [3:0] headSelect;
    } dsfb_drive_t;
    typedef enum logic [1:0] {SEND_IDLE, SEND_BUSY} dsfb_send_t;
endpackage : dsfb_pkg

// ==== hw/dsfb_top.sv ====
// drive status block, recovery setup and track layout handling
// Overview of operation
// - setup bit 7 enables buffer ECC correction
// - setup low nibble sets retries, default fifteen
// - refresh status on completion, error, status request; the block sends bytes 0-2 as sampled live at the request only
// - byte 0 not ready, seek, fault, track zero
// - byte 0 bit 3 overstep, park excluded
// - no step past limit; heads hold position
// - byte 1 check error and failing field
// - byte 1 mark, all ones, mismatch, not found
// - byte 2 reset, retry, defect, head lines
// - bytes 3-6 last ID, size, defect flag
// - bytes 7-8 present cylinder and head
// - corrected count; retry tally halts at 255
// - syndrome 00,01,02,03 progress stages
// - syndrome high nibble accumulates stage flags
// - completion sets low nibble to four
// - byte 12 drive type, byte 13 reserved
// - five bytes per entry, reused per track
// - IDs written in list order
// - entry byte 0 head, defect, cyl high
// - fill byte per sector; all FF bad track
// - attention bit 5 requests the status block
//
// word map seen by the host over the register bus:
//   0 attention, write only
//     bit 5 asks for the fourteen-byte status block
//     bit 6 empties the layout list and format position
//   1 recovery setup, read and write
//     bit 7 buffer correction enable, bits 3..0 retries
//     bits 6..4 always read back as zero
//   2 status block data, one byte per read
//   3 attachment status, read only
//     bit 4 data request, bit 3 direction, bit 1 halted
//   4 layout list byte, write only
//   5 number of whole layout entries stored
// any other word reads zero and ignores writes
//
// bus timing:
//   a request is taken on the edge with cyc and stb high
//   and ack low; ack follows one cycle later for one cycle
//   read data is registered at the taking edge, so it is
//   already valid while ack stands
//   the master must drop cyc and stb after ack; a request
//   held through the ack cycle is not taken twice, because
//   ack itself masks the decode
//
// status block:
//   a snapshot of all fourteen bytes is frozen when the
//   host asks for it, so bytes read later stay coherent
//   even while the sequencer keeps posting events
//   the data request bit stays up until byte 13 is read
//   a fresh request restarts the walk at byte 0
//
// sequencer side:
//   every event input is a one-cycle pulse on our clock
//   the drive pins are the only asynchronous inputs and
//   pass a two-flop synchroniser first
//   overstep and defective-seen flags are sticky and are
//   cleared by the start of the next operation; if both
//   fall in one cycle the set wins
//   the retry tally saturates and holds the halt until a
//   reset, by design, so software must reset the drive
//
// stepping:
//   a target past the last cylinder is refused outright,
//   so the heads never leave the usable range; a run that
//   crosses the limit therefore stops at its last in-range target
//
// formatting:
//   entries are replayed in list order, which is how the
//   host chooses the interleave
//   a whole-disk format reuses the list on each track with
//   two heads assumed: head toggles, cylinder steps on wrap
//   a pad byte after an odd entry count is stored but never
//   forms an entry, since only whole entries are counted
//   bytes past the list capacity are silently dropped
//
// The register offsets and the Wishbone register port were decided locally.
`timescale 1ns/1ps
`include "dsfb_cfg.svh"
module dsfb_top #(
    parameter logic [7:0] DRIVE_TYPE = 8'h5A, // arbitrary value
    parameter int MAX_ENTRIES = 32,
    parameter logic [9:0] LAST_CYL = 10'h3FF
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // classic wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [7:0] wb_dat_i,
    output logic [7:0] wb_dat_o,
    output logic wb_ack_o,
    // drive mechanism status pins, asynchronous
    input wire logic [3:0] drivePins,
    // controller sequencer events, same clock
    input wire dsfb_pkg::dsfb_drive_t driveFlags,
    input wire logic cmdDone,
    input wire logic cmdError,
    input wire logic stageStart,
    input wire logic stageXfer,
    input wire logic stageValid,
    input wire logic stageTrack,
    input wire logic [3:0] stageFlags,
    input wire logic xferDone,
    input wire logic idSeen,
    input wire dsfb_pkg::dsfb_entry_t idField,
    input wire logic eccFixed,
    input wire logic retryPulse,
    input wire logic opStart,
    // step request from the sequencer
    input wire logic stepReq,
    input wire logic stepPark,
    input wire logic [9:0] stepTarget,
    input wire logic [3:0] stepHead,
    // controls to the sequencer and formatter
    output logic eccEnable,
    output logic [3:0] retryLimit,
    output logic halted,
    output logic [9:0] stepTo,
    output logic stepGo,
    // formatter read port for layout entries
    input wire logic fmtNext,
    input wire logic fmtWholeDisk,
    output dsfb_pkg::dsfb_entry_t fmtEntry,
    output logic fmtBadTrack,
    output dsfb_pkg::dsfb_pos_t fmtPos
);
    localparam int IW = $clog2(MAX_ENTRIES);
    // status and setup state
    logic [7:0] setup_reg;
    logic [7:0] stat0_reg, stat1_reg, stat2_reg;
    dsfb_pkg::dsfb_entry_t lastId_reg;
    dsfb_pkg::dsfb_pos_t pos_reg;
    logic [7:0] nsc_reg, retries_reg, syn_reg;
    logic overstep_reg, defSeen_reg;
    logic [7:0] sendBuf_reg [0:13];
    logic [4:0] sendIdx_reg;
    dsfb_pkg::dsfb_send_t send_reg;
    logic [7:0] layout_reg [0:MAX_ENTRIES*5-1];
    logic [$clog2(MAX_ENTRIES*5+1)-1:0] wrPtr_reg;
    logic [IW-1:0] rdIdx_reg;
    logic [3:0] pinMeta_reg, pinSync_reg;
    logic ack_reg;
    logic [7:0] rdData_reg;

    // two-flop sync of drive pins
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pinMeta_reg <= 4'h0;
            pinSync_reg <= 4'h0;
        end else begin
            pinMeta_reg <= drivePins;
            pinSync_reg <= pinMeta_reg;
        end
    end

    // bus decode; ack on the cycle after the strobe, one cycle wide
    wire busReq = wb_cyc_i && wb_stb_i && !ack_reg;
    wire busWr = busReq && wb_we_i;
    wire busRd = busReq && !wb_we_i;
    wire wrCtrl = busWr && wb_adr_i == `DSFB_ADDR_CTRL;
    wire wrSetup = busWr && wb_adr_i == `DSFB_ADDR_SETUP;
    wire wrLayout = busWr && wb_adr_i == `DSFB_ADDR_LAYOUT;
    wire rdData = busRd && wb_adr_i == `DSFB_ADDR_DATA;
    wire sendReq = wrCtrl && wb_dat_i[5];
    wire sending = send_reg == dsfb_pkg::SEND_BUSY;
    wire dataReq = sending;
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdData_reg;

    // setup block: ecc enable and retries, rsvd bits forced zero
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) setup_reg <= `DSFB_SETUP_RST;
        else if (wrSetup) setup_reg <= {wb_dat_i[7], 3'h0, wb_dat_i[3:0]};
    end
    assign eccEnable = setup_reg[`DSFB_ECC_BIT];
    assign retryLimit = setup_reg[3:0];

    // step limit: refuse out-of-range target; stepTo clamped, stepGo held low
    wire overLimit = stepTarget > LAST_CYL;
    // an out-of-range target never moves the heads
    assign stepGo = stepReq && !overLimit;
    assign stepTo = overLimit ? LAST_CYL : stepTarget;
    wire overstep = stepReq && overLimit && !stepPark;

    // composed status bytes
    wire [7:0] st0 = {driveFlags.notReady | pinSync_reg[0],
        driveFlags.seekDone | pinSync_reg[1], 1'b0,
        driveFlags.writeFault | pinSync_reg[2], overstep_reg, 2'b00,
        driveFlags.trackZero | pinSync_reg[3]};
    wire [7:0] st1 = {driveFlags.errorFieldIsId, driveFlags.checkError,
        driveFlags.addressMarkMissing, driveFlags.allOnesId,
        driveFlags.cylinderMismatch, 2'b00, driveFlags.idNotFound};
    wire [7:0] st2 = {1'b0, driveFlags.resetNeeded,
        driveFlags.retryCorrected, defSeen_reg,
        driveFlags.headSelect};
    wire refresh = cmdDone || cmdError || sendReq;

    // sticky flags and snapshot of status bytes
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stat0_reg <= 8'h00;
            stat1_reg <= 8'h00;
            stat2_reg <= 8'h00;
            overstep_reg <= 1'b0;
            defSeen_reg <= 1'b0;
        end else begin
            // set wins over the clear at operation start
            overstep_reg <= overstep | (overstep_reg & !opStart);
            defSeen_reg <= (idSeen & idField.defective)
                | (defSeen_reg & !opStart);
            if (refresh) begin
                stat0_reg <= st0;
                stat1_reg <= st1;
                stat2_reg <= st2;
            end
        end
    end

    // last id, present position, counters
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lastId_reg <= '0;
            pos_reg <= '0;
            nsc_reg <= 8'h00;
            retries_reg <= 8'h00;
        end else begin
            if (idSeen) lastId_reg <= idField;
            if (stepGo) pos_reg <= {stepTo, stepHead};
            if (eccFixed) nsc_reg <= nsc_reg + 8'h01;
            else if (opStart) nsc_reg <= 8'h00;
            if (retryPulse && retries_reg != `DSFB_RETRY_MAX)
                retries_reg <= retries_reg + 8'h01;
            else if (opStart && retries_reg != `DSFB_RETRY_MAX)
                retries_reg <= 8'h00;
        end
    end
    // halt until reset once the tally saturates
    assign halted = retries_reg == `DSFB_RETRY_MAX;

    // command syndrome progression
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) syn_reg <= `DSFB_SYN_START;
        else if (stageStart) syn_reg <= `DSFB_SYN_START;
        else if (stageXfer) syn_reg <= `DSFB_SYN_XFER;
        else if (stageValid) syn_reg <= `DSFB_SYN_VALID;
        else if (stageTrack) syn_reg <= `DSFB_SYN_TRACK;
        else if (xferDone)
            syn_reg <= {syn_reg[7:4], `DSFB_SYN_DONE};
        else if (syn_reg[3:0] >= 4'h3)
            syn_reg <= {syn_reg[7:4] | stageFlags, syn_reg[3:0]};
    end

    // snapshot of the 14-byte block, shifted out ascending
    wire [7:0] snap [0:13];
    assign snap[0] = st0;
    assign snap[1] = st1;
    assign snap[2] = st2;
    assign snap[3] = lastId_reg.cylLow;
    assign snap[4] = {lastId_reg.defective, lastId_reg.cylHigh, 1'b0,
        lastId_reg.head};
    assign snap[5] = lastId_reg.sector;
    assign snap[6] = lastId_reg.sizeCode;
    assign snap[7] = {pos_reg.head, 2'b00, pos_reg.cylHigh};
    assign snap[8] = pos_reg.cylLow;
    assign snap[9] = nsc_reg;
    assign snap[10] = retries_reg;
    assign snap[11] = syn_reg;
    assign snap[12] = DRIVE_TYPE;
    assign snap[13] = 8'h00;
    wire lastByte = sendIdx_reg == `DSFB_STATUS_LEN - 5'h01;

    // send sequencer and its buffer
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            send_reg <= dsfb_pkg::SEND_IDLE;
            sendIdx_reg <= 5'h00;
        end else if (sendReq) begin
            send_reg <= dsfb_pkg::SEND_BUSY;
            sendIdx_reg <= 5'h00;
        end else if (sending && rdData) begin
            sendIdx_reg <= sendIdx_reg + 5'h01;
            if (lastByte) send_reg <= dsfb_pkg::SEND_IDLE;
        end
    end
    generate
        for (genvar i = 0; i < 14; i++) begin : g_snap
            always_ff @(posedge clock) begin
                if (sendReq) sendBuf_reg[i] <= snap[i];
            end
        end
    endgenerate

    // layout list storage, five bytes an entry in arrival order
    wire layoutFull = wrPtr_reg == (MAX_ENTRIES * 5);
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) wrPtr_reg <= '0;
        else if (wrCtrl && wb_dat_i[6]) wrPtr_reg <= '0;
        else if (wrLayout && !layoutFull) wrPtr_reg <= wrPtr_reg + 1'b1;
    end
    always_ff @(posedge clock) begin
        if (wrLayout && !layoutFull) layout_reg[wrPtr_reg] <= wb_dat_i;
    end

    // entry fetch in list order; wraps to reuse on each track
    wire [IW:0] entryCount = (IW+1)'(wrPtr_reg / 5);
    wire [$clog2(MAX_ENTRIES*5+1)-1:0] base = rdIdx_reg * 3'(`DSFB_ENTRY_LEN);
    wire [7:0] eb0 = layout_reg[base];
    assign fmtEntry = {eb0[7:4], eb0[2], eb0[1:0], layout_reg[base + 1],
        layout_reg[base + 2], layout_reg[base + 3],
        layout_reg[base + 4]};
    assign fmtBadTrack = fmtEntry == {4'hF, 1'b1, 2'h3, {4{8'hFF}}}
        && eb0[3] == 1'b1;
    wire trackEnd = fmtNext && ({1'b0, rdIdx_reg} + 1'b1 >= entryCount);
    wire [3:0] nextHead = fmtPos.head + 4'h1;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdIdx_reg <= '0;
            fmtPos <= '0;
        end else if (wrCtrl && wb_dat_i[6]) begin
            rdIdx_reg <= '0;
            fmtPos <= '0;
        end else if (trackEnd) begin
            rdIdx_reg <= '0;
            if (fmtWholeDisk) begin
                fmtPos.head <= nextHead[0] ? nextHead : 4'h0;
                if (!nextHead[0])
                    {fmtPos.cylHigh, fmtPos.cylLow} <=
                        {fmtPos.cylHigh, fmtPos.cylLow} + 10'h001;
            end
        end else if (fmtNext) rdIdx_reg <= rdIdx_reg + 1'b1;
    end

    // bus answer and read mux
    wire [7:0] statusRd = {3'h0, dataReq, sending, 1'b0, halted, 1'b0};
    wire [7:0] dataRd = sending ? sendBuf_reg[sendIdx_reg[3:0]] : 8'h00;
    wire [7:0] rdMux = wb_adr_i == `DSFB_ADDR_SETUP ? setup_reg :
        wb_adr_i == `DSFB_ADDR_DATA ? dataRd :
        wb_adr_i == `DSFB_ADDR_STAT ? statusRd :
        wb_adr_i == `DSFB_ADDR_FMT ? 8'(entryCount) : 8'h00;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
            rdData_reg <= 8'h00;
        end else begin
            ack_reg <= busReq;
            if (busRd) rdData_reg <= rdMux;
        end
    end
endmodule : dsfb_top
